/* src/burst_sram_port.sv */
// Port logic of a separate-I/O double-rate two-word burst SRAM
`timescale 1ns/100ps

// Function
// - Write data sampled on both input edges
// - Write select low at K starts write
// - Deselected write port ignores write data
// - Four nine-bit lanes; narrow uses two
// - Lane enable sampled with its word
// - Disabled lane keeps stored byte
// - Read address at K, write at K-bar
// - Location holds two words, two arrays
// - Two full-depth arrays, one per word
// - Deselected port slot address ignored
// - Read select low at K starts read
// - Pending read completes after deselect
// - Drivers released at next output rise
// - Read bursts two sequential words
// - Accesses start on K rising edge
// - Output edge from C pair or K
// - Bypass cuts read latency by half a K cycle
module burst_sram_port
  import burst_sram_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // Edge phase from the controller clocks, output clock mode
  input  wire logic              k_rise,
  input  wire logic              c_rise,
  input  wire logic              single_clock_mode,
  // Mode straps
  input  wire logic              pll_bypass_n,
  input  wire logic              narrow_mode,
  // Command and address
  input  wire logic              read_port_select_n,
  input  wire logic              write_port_select_n,
  input  wire logic [ADDR_W-1:0] addr,
  // Write data
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [LANES-1:0]  byte_lane_write_enable_n,
  // Read data
  output logic      [DATA_W-1:0] rdata,
  output logic                   rdata_oe
);

  port_state_t       s_r;
  port_state_t       s_nxt;
  logic [LANES-1:0]  lane_ok;
  logic              out_rise;
  logic              launch;

  sram_bank_if bank0_if ();
  sram_bank_if bank1_if ();

  // Lanes usable in the current width
  always_comb begin
    lane_ok = {LANES{1'b1}};
    if (narrow_mode) begin
      lane_ok = {{(LANES-NARROW_LANES){1'b0}}, {NARROW_LANES{1'b1}}};
    end
  end

  // Command, address and data capture pipeline
  always_comb begin
    s_nxt = s_r;
    if (k_rise) begin
      // K rising edge: selects and read address
      s_nxt.w1_v = !write_port_select_n;
      s_nxt.r1_v = !read_port_select_n;
      if (!read_port_select_n) begin
        s_nxt.r1_addr = addr;
      end
      // First write word of the burst begun one cycle back
      s_nxt.w2_v = 1'b0;
      s_nxt.w3_v = s_r.w2_v;
      if (s_r.w2_v) begin
        s_nxt.w3_addr = s_r.w2_addr;
        s_nxt.w3_d0   = wdata;
        s_nxt.w3_m0_n = byte_lane_write_enable_n;
      end
      s_nxt.r3_v = s_r.r2_v;
      s_nxt.r2_v = 1'b0;
    end else begin
      // K-bar rising edge: write address, second write word
      s_nxt.w1_v = 1'b0;
      s_nxt.w2_v = s_r.w1_v;
      if (s_r.w1_v) begin
        s_nxt.w2_addr = addr;
      end
      s_nxt.w3_v = 1'b0;
      s_nxt.r2_v = s_r.r1_v;
      s_nxt.r1_v = 1'b0;
      s_nxt.r3_v = s_r.r3_v && pll_bypass_n;
    end
  end

  // Pipeline register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{w1_v: 1'b0, w2_v: 1'b0, w2_addr: ADDR_RST, w3_v: 1'b0,
               w3_addr: ADDR_RST, w3_d0: DATA_RST, w3_m0_n: MASK_RST,
               r1_v: 1'b0, r1_addr: ADDR_RST, r2_v: 1'b0, r3_v: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Burst commit: word 0 to the first array, word 1 to the second
  always_comb begin
    bank0_if.waddr   = s_r.w3_addr;
    bank0_if.wdata   = s_r.w3_d0;
    bank0_if.lane_we = {LANES{s_r.w3_v && !k_rise}} & ~s_r.w3_m0_n & lane_ok;
    bank1_if.waddr   = s_r.w3_addr;
    bank1_if.wdata   = wdata;
    bank1_if.lane_we = {LANES{s_r.w3_v && !k_rise}} & ~byte_lane_write_enable_n
                       & lane_ok;
  end

  // Fetch both words of a read location at the K-bar edge
  always_comb begin
    bank0_if.re    = s_r.r1_v && !k_rise;
    bank0_if.raddr = s_r.r1_addr;
    bank1_if.re    = s_r.r1_v && !k_rise;
    bank1_if.raddr = s_r.r1_addr;
  end

  // Launch point and output clock reference
  always_comb begin
    if (pll_bypass_n) begin
      launch = s_r.r3_v && !k_rise;
    end else begin
      launch = s_r.r2_v && k_rise;
    end
    out_rise = single_clock_mode ? k_rise : c_rise;
  end

  // Array holding the first word of every location
  sram_bank u_bank0 (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .bif     (bank0_if.bank)
  );

  // Array holding the second word of every location
  sram_bank u_bank1 (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .bif     (bank1_if.bank)
  );

  // Read data drivers
  read_launch u_launch (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .launch   (launch),
    .word0    (bank0_if.rdata),
    .word1    (bank1_if.rdata),
    .out_rise (out_rise),
    .q        (rdata),
    .q_oe     (rdata_oe)
  );

endmodule

/* src/burst_sram_pkg.sv */
// Shared constants and state types for the two-word burst SRAM port logic
package burst_sram_pkg;

  // Geometry of the wide configuration
  localparam int unsigned DATA_W       = 36;
  localparam int unsigned ADDR_W       = 18;
  localparam int unsigned LANES        = 4;
  localparam int unsigned LANE_W       = 9;
  localparam int unsigned NARROW_LANES = 2;
  localparam int unsigned DEPTH        = 2 ** ADDR_W;

  // Clock figures
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned BYPASS_MAX_MHZ = 167;

  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h0_0000;
  localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000;
  localparam logic [LANES-1:0]  MASK_RST = 4'hf;

  // Read launch states
  typedef enum logic [2:0] {
    LAUNCH_IDLE  = 3'b001,
    LAUNCH_WORD1 = 3'b010,
    LAUNCH_DRAIN = 3'b100
  } launch_state_t;

  // Pipeline state of the port logic
  typedef struct packed {
    logic              w1_v;
    logic              w2_v;
    logic [ADDR_W-1:0] w2_addr;
    logic              w3_v;
    logic [ADDR_W-1:0] w3_addr;
    logic [DATA_W-1:0] w3_d0;
    logic [LANES-1:0]  w3_m0_n;
    logic              r1_v;
    logic [ADDR_W-1:0] r1_addr;
    logic              r2_v;
    logic              r3_v;
  } port_state_t;

  // State of the read output stage
  typedef struct packed {
    launch_state_t     st;
    logic [DATA_W-1:0] q;
    logic [DATA_W-1:0] hold;
    logic              oe;
  } launch_reg_t;

endpackage

/* src/sram_bank_if.sv */
// Connection between the port logic and one internal storage array
`timescale 1ns/100ps
interface sram_bank_if;
  import burst_sram_pkg::*;

  logic [ADDR_W-1:0] waddr;
  logic [DATA_W-1:0] wdata;
  logic [LANES-1:0]  lane_we;
  logic              re;
  logic [ADDR_W-1:0] raddr;
  logic [DATA_W-1:0] rdata;

  modport ctrl (output waddr, output wdata, output lane_we, output re, output raddr,
                input rdata);
  modport bank (input waddr, input wdata, input lane_we, input re, input raddr,
                output rdata);
endinterface

/* src/sram_bank.sv */
// One internal storage array, one word per location, written lane by lane
`timescale 1ns/100ps
module sram_bank
  import burst_sram_pkg::*;
(
  // Clock and reset
  input  wire logic   sys_clk,
  input  wire logic   rst_n,
  // Port logic side
  sram_bank_if.bank   bif
);

  logic [DATA_W-1:0] rdata_r;

  // Each lane is its own array so that a masked lane is simply not written
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [LANE_W-1:0] mem [DEPTH];

    // Lane write, left untouched when its enable is off
    always_ff @(posedge sys_clk) begin
      if (bif.lane_we[l]) begin
        mem[bif.waddr] <= bif.wdata[l*LANE_W +: LANE_W];
      end
    end

    // Registered lane read
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        rdata_r[l*LANE_W +: LANE_W] <= 9'h000;
      end else if (bif.re) begin
        rdata_r[l*LANE_W +: LANE_W] <= mem[bif.raddr];
      end
    end
  end

  assign bif.rdata = rdata_r;

endmodule

/* src/read_launch.sv */
// Read output stage: drives the two burst words and the output enable
`timescale 1ns/100ps
module read_launch
  import burst_sram_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // Burst to launch
  input  wire logic              launch,
  input  wire logic [DATA_W-1:0] word0,
  input  wire logic [DATA_W-1:0] word1,
  input  wire logic              out_rise,
  // Read data pins
  output logic      [DATA_W-1:0] q,
  output logic                   q_oe
);

  launch_reg_t s_r;
  launch_reg_t s_nxt;

  // Word sequencing and release of the drivers
  always_comb begin
    s_nxt = s_r;
    if (launch) begin
      s_nxt.q    = word0;
      s_nxt.hold = word1;
      s_nxt.oe   = 1'b1;
      s_nxt.st   = LAUNCH_WORD1;
    end else begin
      case (s_r.st)
        LAUNCH_IDLE: begin
          s_nxt.st = LAUNCH_IDLE;
        end
        LAUNCH_WORD1: begin
          s_nxt.q  = s_r.hold;
          s_nxt.st = LAUNCH_DRAIN;
        end
        LAUNCH_DRAIN: begin
          if (out_rise) begin
            s_nxt.oe = 1'b0;
            s_nxt.st = LAUNCH_IDLE;
          end
        end
        default: begin
          s_nxt.st = LAUNCH_IDLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{st: LAUNCH_IDLE, q: DATA_RST, hold: DATA_RST, oe: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q    = s_r.q;
  assign q_oe = s_r.oe;

endmodule

/* bench/burst_ctrl_model.sv */
// Controller side model: input clock pair and output clock phases
`timescale 1ns/100ps
module burst_ctrl_model (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Clock pair phases
  output logic      k_rise,
  output logic      c_rise
);
  // K and Kb edges alternate, K first after reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      k_rise <= 1'b1;
    end else begin
      k_rise <= ~k_rise;
    end
  end
  // Output clock rises on Kb edges
  assign c_rise = ~k_rise;
endmodule

/* bench/burst_sram_port_assertions.sv */
// Read port timing checks on the port logic pins
`timescale 1ns/100ps
module burst_sram_port_assertions
  import burst_sram_pkg::*;
(
  // Clock, phases, modes and read select
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic              k_rise,
  input wire logic              c_rise,
  input wire logic              single_clock_mode,
  input wire logic              pll_bypass_n,
  input wire logic              read_port_select_n,
  // Read data pins
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              rdata_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic out_rise;
  logic go_pll;
  logic go_byp;
  // Output edge and read starts per latency mode
  assign out_rise = single_clock_mode ? k_rise : c_rise;
  assign go_pll = k_rise && !read_port_select_n && pll_bypass_n;
  assign go_byp = k_rise && !read_port_select_n && !pll_bypass_n;

  read_latency_a: assert property (go_pll |-> ##4 rdata_oe)
    else $error("read data late in normal mode");
  bypass_latency_a: assert property (go_byp |-> ##3 rdata_oe)
    else $error("read data late in bypass mode");
  burst_two_a: assert property (go_pll |-> ##4 rdata_oe [*2])
    else $error("read burst shorter than two words");
  launch_cause_a: assert property ($rose(rdata_oe) |-> $past(go_pll, 4) || $past(go_byp, 3))
    else $error("output enabled without a read at K");
  release_edge_a: assert property ($fell(rdata_oe) |-> $past(out_rise))
    else $error("output released off the output edge");
  stay_driven_a: assert property (rdata_oe && !out_rise |=> rdata_oe)
    else $error("output released early");
  quiet_data_a: assert property ($changed(rdata) |-> rdata_oe)
    else $error("read data moved while not driven");
  reset_quiet_a: assert property ($past(rst_n) == 1'b0 |-> !rdata_oe && rdata == DATA_RST)
    else $error("output active right after reset");
endmodule

bind burst_sram_port burst_sram_port_assertions burst_sram_port_assertions_i (
  .sys_clk, .rst_n, .k_rise, .c_rise, .single_clock_mode, .pll_bypass_n,
  .read_port_select_n, .rdata, .rdata_oe
);

/* bench/testbench.sv */
// Self-checking bench with a reference memory model
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  import burst_sram_pkg::*;
  logic sys_clk = 0, rst_n = 0, k_rise, c_rise, single_clock_mode = 0;
  logic pll_bypass_n = 1, narrow_mode = 0, read_port_select_n = 1, write_port_select_n = 1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata, tmp;
  logic [LANES-1:0]  ben_n = '1;
  logic              rdata_oe;
  logic [15:0]       lfsr_r = 16'h0025;
  logic [DATA_W-1:0] m0[int], m1[int];
  int                err_total = 0, n_compared = 0, ad[4];

  always #2 sys_clk = ~sys_clk;
  burst_ctrl_model burst_ctrl_model_i (.sys_clk, .rst_n, .k_rise, .c_rise);
  burst_sram_port burst_sram_port_i (.sys_clk, .rst_n, .k_rise, .c_rise,
    .single_clock_mode, .pll_bypass_n, .narrow_mode, .read_port_select_n,
    .write_port_select_n, .addr, .wdata, .byte_lane_write_enable_n(ben_n),
    .rdata, .rdata_oe);

  // Random words from the shift register
  function automatic logic [DATA_W-1:0] rnd();
    logic [47:0] v;
    for (int k = 0; k < 3; k++) begin
      lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      v = {v[31:0], lfsr_r};
    end
    return v[DATA_W-1:0];
  endfunction
  // Lane merge of the reference memory
  function automatic logic [DATA_W-1:0] merge(logic [DATA_W-1:0] o, d, logic [3:0] e);
    for (int l = 0; l < 4; l++) begin
      if (!e[l] && (!narrow_mode || l < 2)) o[9*l+:9] = d[9*l+:9];
    end
    return o;
  endfunction
  // Wait until the coming edge is K
  task sync_kb();
    do @(posedge sys_clk); while (k_rise !== 1'b0);
  endtask
  // Write burst: select, address on Kb, then two words
  task wr(int a, logic [DATA_W-1:0] d0, d1, logic [3:0] e0, e1);
    sync_kb();
    write_port_select_n <= 1'b0;
    @(posedge sys_clk);
    write_port_select_n <= 1'b1;
    addr <= a[ADDR_W-1:0];
    @(posedge sys_clk);
    wdata <= d0;
    ben_n <= e0;
    @(posedge sys_clk);
    wdata <= d1;
    ben_n <= e1;
    @(posedge sys_clk);
    wdata <= rnd();
    ben_n <= 4'h0;
    // Unwritten locations start from zero in the model
    m0[a] = merge(m0.exists(a) ? m0[a] : DATA_RST, d0, e0);
    m1[a] = merge(m1.exists(a) ? m1[a] : DATA_RST, d1, e1);
  endtask
  // Read burst and check both words and the release
  task rd(int a, logic pll);
    sync_kb();
    read_port_select_n <= 1'b0;
    addr <= a[ADDR_W-1:0];
    @(posedge sys_clk);
    tmp = rnd();
    read_port_select_n <= 1'b1;
    addr <= tmp[ADDR_W-1:0];
    repeat (pll ? 3 : 2) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(rdata, m0[a])
    `CHK(rdata_oe, 1'b1)
    @(negedge sys_clk);
    `CHK(rdata, m1[a])
    repeat (6) @(posedge sys_clk);
    `CHK(rdata_oe, 1'b0)
  endtask
  task conclude();
    $display("compared=%0d errors=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Main sequence: fill, then masked writes across all modes
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      tmp = rnd();
      ad[i] = int'(tmp[ADDR_W-1:0]);
      wr(ad[i], rnd(), rnd(), 4'h0, 4'h0);
      rd(ad[i], 1'b1);
    end
    for (int i = 0; i < 16; i++) begin
      tmp = rnd();
      @(posedge sys_clk);
      narrow_mode <= i[3];
      pll_bypass_n <= i[0];
      single_clock_mode <= i[1];
      @(posedge sys_clk);
      wr(ad[i%4], rnd(), rnd(), tmp[3:0], tmp[7:4]);
      rd(ad[i%4], i[0]);
    end
    conclude();
  end
  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge sys_clk);
    err_total++;
    conclude();
  end
endmodule
